// *** rtl/pwmgen_ctrl.sv ***
// Purpose: One PWM generator with its control registers on APB.
// Assumes: Event pins are asynchronous; APB is on CLK_I.
// Notes:   APB answers with PREADY in the access cycle; no wait states.
`timescale 1ns/10ps
module pwmgen_ctrl
    import pwmgen_pkg::*;
(
    // Clock and reset
    input  wire logic         CLK_I,
    input  wire logic         RESETN_I,
    // APB slave
    input  wire logic         PSEL_I,
    input  wire logic         PENABLE_I,
    input  wire logic         PWRITE_I,
    input  wire logic [7:0]   PADDR_I,
    input  wire logic [31:0]  PWDATA_I,
    output logic [31:0]       PRDATA_O,
    output logic              PREADY_O,
    output logic              PSLVERR_O,
    // Event pins
    input  wire logic         FAULT_I,
    input  wire logic         CLIMIT_I,
    input  wire logic         TRIGGER_I,
    // Outputs
    output logic              PWM_H_O,
    output logic              PWM_L_O,
    output logic              IRQ_FAULT_O,
    output logic              IRQ_CLIMIT_O,
    output logic              IRQ_TRIGGER_O
);

    // ------------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------------
    logic [15:0] master_duty_q;
    logic [15:0] local_duty_q;
    logic [15:0] ctrl_q;
    logic [15:0] phase_q;
    logic [15:0] dead_q;
    logic [15:0] period_q;
    logic [15:0] active_duty_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        pend_fault_q;
    logic        pend_climit_q;
    logic        pend_trig_q;
    logic        pwm_raw_q;
    pwmgen_evt_s evt_sync;
    pwmgen_evt_s evt_prev_q;
    pwmgen_pair_s pair;

    wire acc_w      = PSEL_I & PENABLE_I;
    wire wr_w       = acc_w & PWRITE_I;
    wire wr_mdc_w   = wr_w & (PADDR_I == OFS_MASTER_DUTY);
    wire wr_ctrl_w  = wr_w & (PADDR_I == OFS_GEN_CTRL);
    wire wr_ldc_w   = wr_w & (PADDR_I == OFS_LOCAL_DUTY);
    wire wr_phase_w = wr_w & (PADDR_I == OFS_PHASE);
    wire wr_dead_w  = wr_w & (PADDR_I == OFS_DEAD_TIME);
    wire wr_per_w   = wr_w & (PADDR_I == OFS_PRIM_PERIOD);
    wire mapped_w   = (PADDR_I == OFS_MASTER_DUTY) | (PADDR_I == OFS_GEN_CTRL)
                    | (PADDR_I == OFS_LOCAL_DUTY) | (PADDR_I == OFS_PHASE)
                    | (PADDR_I == OFS_DEAD_TIME) | (PADDR_I == OFS_PRIM_PERIOD)
                    | (PADDR_I == OFS_STATUS);

    wire fault_ien_w  = ctrl_q[BIT_FLT_IEN];
    wire climit_ien_w = ctrl_q[BIT_CL_IEN];
    wire trig_ien_w   = ctrl_q[BIT_TRG_IEN];
    wire own_per_w    = ctrl_q[BIT_OWN_PER];
    wire shr_duty_w   = ctrl_q[BIT_SHR_DUTY];
    wire xrst_w       = ctrl_q[BIT_XRST];
    wire imm_upd_w    = ctrl_q[BIT_IMM_UPD];
    wire [1:0] dtc_w  = ctrl_q[BIT_DTC_HI:BIT_DTC_LO];

    // Status bits are live; the stored enables sit in writable positions only.
    wire [15:0] ctrl_rd_w = (ctrl_q & MASK_CTRL_WR)
                          | ({15'h0000, pend_fault_q} << BIT_FLT_STAT)
                          | ({15'h0000, pend_climit_q} << BIT_CL_STAT)
                          | ({15'h0000, pend_trig_q} << BIT_TRG_STAT);

    logic [15:0] rd_w;
    always_comb begin
        case (PADDR_I)
            OFS_MASTER_DUTY: rd_w = master_duty_q;
            OFS_GEN_CTRL:    rd_w = ctrl_rd_w;
            OFS_LOCAL_DUTY:  rd_w = local_duty_q;
            OFS_PHASE:       rd_w = phase_q;
            OFS_DEAD_TIME:   rd_w = dead_q;
            OFS_PRIM_PERIOD: rd_w = period_q;
            OFS_STATUS:      rd_w = count_q;
            default:         rd_w = RST_ZERO16;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            master_duty_q <= RST_ZERO16;
            local_duty_q  <= RST_ZERO16;
            ctrl_q        <= RST_ZERO16;
            phase_q       <= RST_ZERO16;
            dead_q        <= RST_ZERO16;
            period_q      <= RST_ZERO16;
        end else begin
            if (wr_mdc_w)   master_duty_q <= PWDATA_I[15:0];
            if (wr_ldc_w)   local_duty_q  <= PWDATA_I[15:0];
            if (wr_ctrl_w)  ctrl_q        <= PWDATA_I[15:0] & MASK_CTRL_WR;
            if (wr_phase_w) phase_q       <= PWDATA_I[15:0] & MASK_PHASE;
            if (wr_dead_w)  dead_q        <= PWDATA_I[15:0] & MASK_DEAD;
            if (wr_per_w)   period_q      <= PWDATA_I[15:0] & MASK_PERIOD;
        end
    end

    // Zero wait states keeps the slave simple; reads are registered.
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            PRDATA_O  <= RD_UNMAPPED;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped_w;
            PRDATA_O  <= (PSEL_I & ~PENABLE_I) ? {16'h0000, rd_w} : RD_UNMAPPED;
        end
    end

    // ------------------------------------------------------------------
    // Events and pending flags
    // ------------------------------------------------------------------
    pwmgen_sync2 u_sync_fault (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .d_i      (FAULT_I),
        .q_o      (evt_sync.fault)
    );
    pwmgen_sync2 u_sync_climit (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .d_i      (CLIMIT_I),
        .q_o      (evt_sync.climit)
    );
    pwmgen_sync2 u_sync_trig (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .d_i      (TRIGGER_I),
        .q_o      (evt_sync.trigger)
    );

    wire fault_rise_w  = evt_sync.fault & ~evt_prev_q.fault;
    wire climit_rise_w = evt_sync.climit & ~evt_prev_q.climit;
    wire trig_rise_w   = evt_sync.trigger & ~evt_prev_q.trigger;

    // The enable after this write decides; an event with enable low never sets.
    wire fault_en_nx_w  = wr_ctrl_w ? PWDATA_I[BIT_FLT_IEN] : fault_ien_w;
    wire climit_en_nx_w = wr_ctrl_w ? PWDATA_I[BIT_CL_IEN]  : climit_ien_w;
    wire trig_en_nx_w   = wr_ctrl_w ? PWDATA_I[BIT_TRG_IEN] : trig_ien_w;

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            evt_prev_q    <= '0;
            pend_fault_q  <= 1'b0;
            pend_climit_q <= 1'b0;
            pend_trig_q   <= 1'b0;
        end else begin
            evt_prev_q    <= evt_sync;
            pend_fault_q  <= fault_en_nx_w & (pend_fault_q | fault_rise_w);
            pend_climit_q <= climit_en_nx_w & (pend_climit_q | climit_rise_w);
            pend_trig_q   <= trig_en_nx_w & (pend_trig_q | trig_rise_w);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            IRQ_FAULT_O   <= 1'b0;
            IRQ_CLIMIT_O  <= 1'b0;
            IRQ_TRIGGER_O <= 1'b0;
        end else begin
            IRQ_FAULT_O   <= pend_fault_q;
            IRQ_CLIMIT_O  <= pend_climit_q;
            IRQ_TRIGGER_O <= pend_trig_q;
        end
    end

    // ------------------------------------------------------------------
    // Time base, duty and output
    // ------------------------------------------------------------------
    wire [15:0] per_sel_w = own_per_w ? (phase_q & MASK_OWN_PER)
                                      : (period_q & MASK_PERIOD);
    wire        ext_rst_w = xrst_w & own_per_w & evt_sync.climit;
    wire        wrap_w    = (count_q >= per_sel_w);
    wire [15:0] duty_sel_w = shr_duty_w ? master_duty_q : local_duty_q;

    assign count_d = (wrap_w | ext_rst_w) ? RST_ZERO16 : count_q + ONE16;

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            count_q       <= RST_ZERO16;
            active_duty_q <= RST_ZERO16;
            pwm_raw_q     <= 1'b0;
        end else begin
            count_q <= count_d;
            if (imm_upd_w | wrap_w)
                active_duty_q <= duty_sel_w;
            pwm_raw_q <= (count_q < active_duty_q);
        end
    end

    pwmgen_deadtime u_dead (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .mode_i   (dtc_w),
        .dead_i   (dead_q[13:2]),
        .raw_i    (pwm_raw_q),
        .pair_o   (pair)
    );

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            PWM_H_O <= 1'b0;
            PWM_L_O <= 1'b0;
        end else begin
            PWM_H_O <= pair.hi;
            PWM_L_O <= pair.lo;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    fault_flag_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (fault_rise_w && fault_en_nx_w) |=> pend_fault_q)
        else $error("fault flag not set");
    climit_flag_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (wr_ctrl_w && !PWDATA_I[BIT_CL_IEN]) |=> !pend_climit_q)
        else $error("climit flag not cleared");
    trig_flag_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (trig_rise_w && trig_en_nx_w) |=> pend_trig_q)
        else $error("trigger flag not set");
    fault_irq_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        IRQ_FAULT_O |-> $past(fault_ien_w))
        else $error("fault irq while disabled");
    climit_irq_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        pend_climit_q |=> IRQ_CLIMIT_O)
        else $error("climit irq missing");
    trig_irq_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !pend_trig_q |=> !IRQ_TRIGGER_O)
        else $error("trigger irq spurious");
    ext_reset_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        ext_rst_w |=> (count_q == RST_ZERO16))
        else $error("time base not reset");
    duty_load_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (!imm_upd_w && !wrap_w) |=> $stable(active_duty_q))
        else $error("duty loaded off period");
    ctrl_zero_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (ctrl_q & ~MASK_CTRL_WR) == RST_ZERO16)
        else $error("unimplemented ctrl bit set");
    pwm_cmp_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (count_q < active_duty_q) |=> pwm_raw_q)
        else $error("raw pwm low below duty");

    // ------------------------------------------------------------------
    // Event paths and register invariants
    // ------------------------------------------------------------------
    sequence fault_taken_seq;
        fault_rise_w && fault_en_nx_w;
    endsequence
    sequence fault_shown_seq;
        pend_fault_q ##1 IRQ_FAULT_O;
    endsequence
    sequence climit_taken_seq;
        climit_rise_w && climit_en_nx_w;
    endsequence
    sequence climit_shown_seq;
        pend_climit_q ##1 IRQ_CLIMIT_O;
    endsequence
    sequence trig_taken_seq;
        trig_rise_w && trig_en_nx_w;
    endsequence
    sequence trig_shown_seq;
        pend_trig_q ##1 IRQ_TRIGGER_O;
    endsequence
    fault_path_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        fault_taken_seq |=> fault_shown_seq)
        else $error("fault request missing");
    climit_path_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        climit_taken_seq |=> climit_shown_seq)
        else $error("climit request missing");
    trig_path_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        trig_taken_seq |=> trig_shown_seq)
        else $error("trigger request missing");
    fault_clear_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (wr_ctrl_w && !PWDATA_I[BIT_FLT_IEN]) |=> !pend_fault_q ##1 !IRQ_FAULT_O)
        else $error("fault flag not cleared");
    trig_clear_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (wr_ctrl_w && !PWDATA_I[BIT_TRG_IEN]) |=> !pend_trig_q ##1 !IRQ_TRIGGER_O)
        else $error("trigger flag not cleared");
    shared_duty_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (imm_upd_w && shr_duty_w) |=> (active_duty_q == $past(master_duty_q)))
        else $error("shared duty not applied");
    local_duty_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (imm_upd_w && !shr_duty_w) |=> (active_duty_q == $past(local_duty_q)))
        else $error("local duty not applied");
    count_step_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (!xrst_w && !wrap_w) |=> (count_q == $past(count_q) + ONE16))
        else $error("time base disturbed");
    own_wrap_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (own_per_w && (count_q == (phase_q & MASK_OWN_PER))) |=> (count_q == RST_ZERO16))
        else $error("own period not honoured");
    prim_wrap_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (!own_per_w && (count_q == period_q)) |=> (count_q == RST_ZERO16))
        else $error("primary period not honoured");
    phase_mask_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (phase_q & ~MASK_PHASE) == RST_ZERO16)
        else $error("unimplemented phase bit set");
    dead_mask_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (dead_q & ~MASK_DEAD) == RST_ZERO16)
        else $error("unimplemented dead-time bit set");
    period_mask_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        (period_q & ~MASK_PERIOD) == RST_ZERO16)
        else $error("unimplemented period bit set");
    mdc_write_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        wr_mdc_w |=> (master_duty_q == $past(PWDATA_I[15:0])))
        else $error("master duty write lost");
    ldc_write_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        wr_ldc_w |=> (local_duty_q == $past(PWDATA_I[15:0])))
        else $error("local duty write lost");
    phase_write_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        wr_phase_w |=> (phase_q == ($past(PWDATA_I[15:0]) & MASK_PHASE)))
        else $error("phase write lost");
endmodule

// *** rtl/pwmgen_pkg.sv ***
// Purpose: Shared constants and types for the PWM generator control block.
// Assumes: 16-bit registers, one aligned 32-bit APB word per register.
// Notes:   Offsets are byte addresses.
package pwmgen_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MASTER_DUTY  = 8'h00;
    localparam logic [7:0] OFS_GEN_CTRL     = 8'h04;
    localparam logic [7:0] OFS_LOCAL_DUTY   = 8'h08;
    localparam logic [7:0] OFS_PHASE        = 8'h0c;
    localparam logic [7:0] OFS_DEAD_TIME    = 8'h10;
    localparam logic [7:0] OFS_PRIM_PERIOD  = 8'h14;
    localparam logic [7:0] OFS_STATUS       = 8'h18;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int BIT_FLT_STAT  = 15;
    localparam int BIT_CL_STAT   = 14;
    localparam int BIT_TRG_STAT  = 13;
    localparam int BIT_FLT_IEN   = 12;
    localparam int BIT_CL_IEN    = 11;
    localparam int BIT_TRG_IEN   = 10;
    localparam int BIT_OWN_PER   = 9;
    localparam int BIT_SHR_DUTY  = 8;
    localparam int BIT_DTC_HI    = 7;
    localparam int BIT_DTC_LO    = 6;
    localparam int BIT_XRST      = 1;
    localparam int BIT_IMM_UPD   = 0;

    // Writable masks; all other bits ignore writes and read zero, except control bits 15:13, which read the pending flags.
    localparam logic [15:0] MASK_CTRL_WR = 16'h1fc3;
    localparam logic [15:0] MASK_PHASE   = 16'hfffc;
    localparam logic [15:0] MASK_DEAD    = 16'h3ffc;
    localparam logic [15:0] MASK_PERIOD  = 16'hfff8;
    localparam logic [15:0] MASK_OWN_PER = 16'hfff0;
    localparam logic [15:0] RST_ZERO16   = 16'h0000;
    localparam logic [15:0] ONE16        = 16'h0001;
    localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWMGEN_DT_POS = 2'b00,
        PWMGEN_DT_NEG = 2'b01,
        PWMGEN_DT_OFF = 2'b10,
        PWMGEN_DT_RSV = 2'b11
    } pwmgen_dtc_e;

    typedef struct packed {
        logic        hi;
        logic        lo;
    } pwmgen_pair_s;

    typedef struct packed {
        logic        fault;
        logic        climit;
        logic        trigger;
    } pwmgen_evt_s;

endpackage

// *** rtl/pwmgen_sync2.sv ***
// Purpose: Two-flop synchroniser for asynchronous event pins.
// Assumes: Inputs are slow levels relative to the clock.
// Notes:   The first stage feeds only the second.
`timescale 1ns/10ps
module pwmgen_sync2 (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_q <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// *** rtl/pwmgen_deadtime.sv ***
// Purpose: Turns one raw PWM level into a complementary pair with dead time.
// Assumes: Dead-time count is in clock cycles.
// Notes:   Negative dead time widens the active output into the gap.
`timescale 1ns/10ps
module pwmgen_deadtime
    import pwmgen_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Control
    input  wire logic [1:0]   mode_i,
    input  wire logic [11:0]  dead_i,
    input  wire logic         raw_i,
    // Outputs
    output pwmgen_pair_s      pair_o
);
    logic        raw_q;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    wire         edge_w = raw_i ^ raw_q;
    wire         gap_w  = (cnt_q != 12'h000);
    // The edge cycle is itself the first dead cycle, so a count of one ends the gap.
    wire         blank_w = (edge_w & (dead_i != 12'h000)) | (cnt_q > 12'h001);

    assign cnt_d = edge_w ? dead_i : (gap_w ? cnt_q - 12'h001 : cnt_q);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            raw_q  <= 1'b0;
            cnt_q  <= 12'h000;
            pair_o <= '0;
        end else begin
            raw_q <= raw_i;
            cnt_q <= cnt_d;
            case (pwmgen_dtc_e'(mode_i))
                PWMGEN_DT_POS: begin
                    pair_o.hi <= raw_i & ~blank_w;
                    pair_o.lo <= ~raw_i & ~blank_w;
                end
                PWMGEN_DT_NEG: begin
                    pair_o.hi <= raw_i | blank_w;
                    pair_o.lo <= ~raw_i | blank_w;
                end
                PWMGEN_DT_OFF: begin
                    pair_o.hi <= raw_i;
                    pair_o.lo <= ~raw_i;
                end
                default: begin
                    pair_o.hi <= 1'b0;
                    pair_o.lo <= 1'b0;
                end
            endcase
        end
    end
endmodule

// *** sim/pwmgen_stage.sv ***
// Purpose: Far-side power stage model that watches the gate pair.
// Assumes: One clock; the bench clears the counters before each window.
// Notes:   Counts high, overlap and gap cycles and the high-side period.
`timescale 1ns/10ps
module pwmgen_stage (
    // Clock and control
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    // Gate drive
    input  wire logic        hi_i,
    input  wire logic        lo_i,
    // Observations
    output logic [15:0]      hi_cnt_o,
    output logic [15:0]      ov_cnt_o,
    output logic [15:0]      gap_cnt_o,
    output logic [15:0]      per_o
);
    logic        hi_q;
    logic [15:0] since_q;

    // ------------------------------------------------------------------
    // Gate observation
    // ------------------------------------------------------------------
    // Both gates on is shoot-through in a real bridge, so it is counted.
    always_ff @(posedge clk_i) begin
        hi_q <= hi_i;
        if (hi_i && !hi_q) begin
            per_o   <= since_q;
            since_q <= 16'h0001;
        end else begin
            since_q <= since_q + 16'h0001;
        end
        if (clr_i) begin
            hi_cnt_o  <= 16'h0000;
            ov_cnt_o  <= 16'h0000;
            gap_cnt_o <= 16'h0000;
        end else begin
            hi_cnt_o  <= hi_cnt_o + {15'h0000, hi_i};
            ov_cnt_o  <= ov_cnt_o + {15'h0000, hi_i & lo_i};
            gap_cnt_o <= gap_cnt_o + {15'h0000, ~hi_i & ~lo_i};
        end
    end
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the PWM generator control block.
// Assumes: Zero-wait APB slave; event pins pass a two-flop synchroniser.
// Notes:   Duty and period figures are chosen small to keep windows short.
`timescale 1ns/10ps
module tb;
    import pwmgen_pkg::*;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic        clr    = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    pwmgen_evt_s evt    = 3'b000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        pwm_h;
    logic        pwm_l;
    logic [2:0]  irq;
    logic [15:0] hc;
    logic [15:0] oc;
    logic [15:0] gc;
    logic [15:0] per;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    pwmgen_ctrl dut (.CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FAULT_I(evt.fault),
        .CLIMIT_I(evt.climit), .TRIGGER_I(evt.trigger), .PWM_H_O(pwm_h), .PWM_L_O(pwm_l),
        .IRQ_FAULT_O(irq[2]), .IRQ_CLIMIT_O(irq[1]), .IRQ_TRIGGER_O(irq[0]));
    pwmgen_stage stage (.clk_i(clk), .clr_i(clr), .hi_i(pwm_h), .lo_i(pwm_l),
        .hi_cnt_o(hc), .ov_cnt_o(oc), .gap_cnt_o(gc), .per_o(per));

    initial begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request is held until pready is sampled high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, rd, exp);
    endtask

    // Lets the waveform settle, then counts exactly w sampled cycles.
    task automatic meas(input int w);
        repeat (140) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (w) @(posedge clk);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] ofs [7] = '{OFS_MASTER_DUTY, OFS_GEN_CTRL, OFS_LOCAL_DUTY, OFS_PHASE,
                                OFS_DEAD_TIME, OFS_PRIM_PERIOD, OFS_STATUS};
        foreach (ofs[i]) rchk("reset value", ofs[i], 32'h0000_0000);
        apb(1'b0, 8'h1c, 32'h0000_0000);
        chk("unmapped data", rd, 32'h0000_0000);
        chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
        $display("test reset done");
    endtask

    task automatic t_masks();
        logic [7:0]  a [6] = '{OFS_MASTER_DUTY, OFS_LOCAL_DUTY, OFS_GEN_CTRL, OFS_PHASE,
                               OFS_DEAD_TIME, OFS_PRIM_PERIOD};
        logic [15:0] v [6] = '{16'hffef, 16'h0008, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
        logic [15:0] e [6] = '{16'hffef, 16'h0008, 16'h1fc3, 16'hfffc, 16'h3ffc, 16'hfff8};
        foreach (a[i]) begin
            apb(1'b1, a[i], {16'hffff, v[i]});
            rchk("register mask", a[i], {16'h0000, e[i]});
        end
        apb(1'b1, OFS_GEN_CTRL, 32'h0000_0000);
        $display("test masks done");
    endtask

    task automatic t_events();
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_GEN_CTRL, 32'h0000_1000 >> i);
            evt <= 3'b111;
            repeat (4) @(posedge clk);
            evt <= 3'b000;
            repeat (4) @(posedge clk);
            chk("irq lines", {29'h0000_0000, irq}, 32'h0000_0004 >> i);
            rchk("flag set", OFS_GEN_CTRL, 32'h0000_9000 >> i);
            apb(1'b1, OFS_GEN_CTRL, 32'h0000_0000);
            rchk("flag cleared", OFS_GEN_CTRL, 32'h0000_0000);
            chk("irq cleared", {29'h0000_0000, irq}, 32'h0000_0000);
        end
        $display("test events done");
    endtask

    task automatic t_pwm();
        logic [31:0] ovx [4] = '{32'd0, 32'd16, 32'd0, 32'd0};
        logic [31:0] gpx [4] = '{32'd16, 32'd0, 32'd0, 32'd130};
        apb(1'b1, OFS_PRIM_PERIOD, 32'h0000_0040);
        apb(1'b1, OFS_LOCAL_DUTY, 32'h0000_0010);
        apb(1'b1, OFS_MASTER_DUTY, 32'h0000_0020);
        apb(1'b1, OFS_PHASE, 32'h0000_002c);
        apb(1'b1, OFS_DEAD_TIME, 32'h0000_0010);
        apb(1'b1, OFS_GEN_CTRL, 32'h0000_0081);
        meas(130);
        chk("high time local", {16'h0000, hc}, 32'd32);
        chk("primary period", {16'h0000, per}, 32'd65);
        apb(1'b1, OFS_GEN_CTRL, 32'h0000_0181);
        meas(130);
        chk("high time shared", {16'h0000, hc}, 32'd64);
        apb(1'b1, OFS_GEN_CTRL, 32'h0000_0281);
        meas(66);
        chk("high time own", {16'h0000, hc}, 32'd32);
        chk("own period", {16'h0000, per}, 32'd33);
        @(posedge clk);
        evt <= 3'b010;
        apb(1'b1, OFS_GEN_CTRL, 32'h0000_0283);
        meas(66);
        chk("held time base", {16'h0000, hc}, 32'd66);
        apb(1'b1, OFS_GEN_CTRL, 32'h0000_0281);
        meas(66);
        chk("pin ignored", {16'h0000, hc}, 32'd32);
        @(posedge clk);
        evt <= 3'b000;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_GEN_CTRL, 32'h0000_0001 | (32'(c) << 6));
            meas(130);
            chk("overlap", {16'h0000, oc}, ovx[c]);
            chk("gap", {16'h0000, gc}, gpx[c]);
        end
        $display("test pwm done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_masks();
        t_events();
        t_pwm();
        conclude();
    end
endmodule
